// ---- rtl/gpp_ports.sv ----
// Two four-bit general-purpose ports with their software registers.
// Port 0 also hands its pins to the high- and low-frequency oscillators;
// port 1 pin 0 belongs to the external reset input until released.
// Assumes a byte register port with one-cycle strobes and read data one
// cycle after the read strobe, and pads that resolve pin, output and
// output enable into the real wire.
`timescale 1ns/1ps

// Functional notes
// [R01] Port 0: four pins, per-bit direction, oscillator pins.
// [R02] Port 0 output latch, reset zero, drives pins.
// [R03] Port 0 direction bits, reset zero, 1 output.
// [R04] Software keeps pin 0/1 direction at zero.
// [R05] Function bits 0 and 2 select oscillators.
// [R06] Clearing bit 0 with oscillator on resets.
// [R07] Pull-up connects only in input mode.
// [R08] Pin-input bits 0/1 gated by function, direction.
// [R09] Pin-input bits 2/3 gated by function, direction.
// [R10] Port 1: four pins, direction, secondary inputs.
// [R11] Port 1 pin 0 is reset until released.
// [R12] Port 1 output latch, reset zero, drives pins.
// [R13] Upper four bits read zero, ignore writes.
module gpp_ports #(
    parameter int PINS = gpp_pkg::PIN_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [gpp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [gpp_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [gpp_pkg::DATA_W-1:0] regRdata,
    // System side.
    input wire logic hfOscEnable,
    output logic sysClkResetReq,
    output logic hfOscSelect,
    output logic lfOscSelect,
    output logic extResetInN,
    output logic [PINS-1:1] p1SecondaryIn,
    // Port 0 pads.
    input wire logic [PINS-1:0] p0PinIn,
    output logic [PINS-1:0] p0PinOut,
    output logic [PINS-1:0] p0PinOe,
    output logic [PINS-1:0] p0PullupOn,
    // Port 1 pads.
    input wire logic [PINS-1:0] p1PinIn,
    output logic [PINS-1:0] p1PinOut,
    output logic [PINS-1:0] p1PinOe
);

    // Register state.
    logic [PINS-1:0] p0Out_q;
    logic [PINS-1:0] p1Out_q;
    logic [PINS-1:0] p0Dir_q;
    logic [PINS-1:0] p1Dir_q;
    logic [PINS-1:0] port0_pullup_enable_q;
    logic hfSel_q;
    logic lfSel_q;
    logic p1RstOwned_q;
    logic sysRst_q;
    logic [gpp_pkg::DATA_W-1:0] rdata_q;

    // Synchronised pin levels.
    logic [PINS-1:0] p0Level;
    logic [PINS-1:0] p1Level;

    // Decode.
    wire hitP0Out = (regAddr == gpp_pkg::OFF_P0_OUT);
    wire hitP1Out = (regAddr == gpp_pkg::OFF_P1_OUT);
    wire hitP0Pin = (regAddr == gpp_pkg::OFF_P0_PIN);
    wire hitP0Dir = (regAddr == gpp_pkg::OFF_P0_DIR);
    wire hitP1Dir = (regAddr == gpp_pkg::OFF_P1_DIR);
    wire hitP0Pu = (regAddr == gpp_pkg::OFF_P0_PU);
    wire hitP0Func = (regAddr == gpp_pkg::OFF_P0_FUNC);
    wire hitP1Rel = (regAddr == gpp_pkg::OFF_P1_RST_REL);
    wire hitP1Pin = (regAddr == gpp_pkg::OFF_P1_PIN);

    wire wrP0Out = regWr & hitP0Out;
    wire wrP1Out = regWr & hitP1Out;
    wire wrP0Dir = regWr & hitP0Dir;
    wire wrP1Dir = regWr & hitP1Dir;
    wire wrP0Pu = regWr & hitP0Pu;
    wire wrP0Func = regWr & hitP0Func;
    wire wrP1Rel = regWr & hitP1Rel;

    // Only the low nibble is ever stored.
    wire [PINS-1:0] wrNibble = regWdata[PINS-1:0]; // R13

    // Function select as a nibble, with unimplemented bits at zero.
    wire [3:0] funcNibble = {1'b0, lfSel_q, 1'b0, hfSel_q};

    // Oscillator ownership per pin: pins 0/1 follow the high-frequency
    // select, pins 2/3 the low-frequency select.
    wire [PINS-1:0] oscOwned = {lfSel_q, lfSel_q, hfSel_q, hfSel_q}; // R01

    // Pin-input masking.
    wire [PINS-1:0] p0Readable = ~p0Dir_q & ~oscOwned; // R08 R09
    wire [PINS-1:0] p0PinRead = p0Level & p0Readable;

    // Port 1 pin 0 reads as zero while the reset function owns it.
    wire [PINS-1:0] p1Owned = {{(PINS-1){1'b0}}, p1RstOwned_q};
    wire [PINS-1:0] p1PinRead = p1Level & ~p1Dir_q & ~p1Owned;

    // Clearing the high-frequency select while the oscillator runs
    // raises a system clock reset request.
    wire hfClearHit = wrP0Func & hfOscEnable & ~regWdata[gpp_pkg::FUNC_HF_BIT]; // R06

    // Read mux; unmapped addresses read zero.
    function automatic logic [7:0] padByte(input logic [3:0] nib);
        padByte = {4'h0, nib}; // R13
    endfunction

    wire [7:0] rdMux =
        hitP0Out  ? padByte(p0Out_q) :
        hitP1Out  ? padByte(p1Out_q) :
        hitP0Pin  ? padByte(p0PinRead) :
        hitP0Dir  ? padByte(p0Dir_q) :
        hitP1Dir  ? padByte(p1Dir_q) :
        hitP0Pu   ? padByte(port0_pullup_enable_q) :
        hitP0Func ? padByte(funcNibble & gpp_pkg::FUNC_IMPL_MASK) :
        hitP1Rel  ? padByte({3'h0, ~p1RstOwned_q}) :
        hitP1Pin  ? padByte(p1PinRead) :
        8'h00;

    gpp_pin_sync #(
        .WIDTH(PINS)
    ) u_p0_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinAsync(p0PinIn),
        .pinLevel(p0Level)
    );

    gpp_pin_sync #(
        .WIDTH(PINS)
    ) u_p1_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinAsync(p1PinIn),
        .pinLevel(p1Level)
    );

    // Output latches.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            p0Out_q <= gpp_pkg::RST_P0_OUT[PINS-1:0]; // R02
            p1Out_q <= gpp_pkg::RST_P1_OUT[PINS-1:0]; // R12
        end else begin
            if (wrP0Out) begin
                p0Out_q <= wrNibble; // R02
            end
            if (wrP1Out) begin
                p1Out_q <= wrNibble; // R12
            end
        end
    end

    // Direction registers. Pins 0 and 1 of port 0 are stored as written;
    // keeping them at zero is software's job, and the oscillator select
    // still blocks the driver while it owns those pins.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            p0Dir_q <= gpp_pkg::RST_P0_DIR[PINS-1:0]; // R03
            p1Dir_q <= gpp_pkg::RST_P1_DIR[PINS-1:0]; // R10
        end else begin
            if (wrP0Dir) begin
                p0Dir_q <= wrNibble; // R03 R04
            end
            if (wrP1Dir) begin
                p1Dir_q <= wrNibble; // R10
            end
        end
    end

    // Pull-up enables.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port0_pullup_enable_q <= gpp_pkg::RST_P0_PU[PINS-1:0]; // R07
        end else if (wrP0Pu) begin
            port0_pullup_enable_q <= wrNibble; // R07
        end
    end

    // Function select: only bits 0 and 2 exist.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hfSel_q <= gpp_pkg::RST_P0_FUNC[gpp_pkg::FUNC_HF_BIT]; // R05
            lfSel_q <= gpp_pkg::RST_P0_FUNC[gpp_pkg::FUNC_LF_BIT]; // R05
        end else if (wrP0Func) begin
            hfSel_q <= regWdata[gpp_pkg::FUNC_HF_BIT]; // R05
            lfSel_q <= regWdata[gpp_pkg::FUNC_LF_BIT]; // R05
        end
    end

    // System clock reset request, one cycle long after the offending write.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sysRst_q <= 1'b0;
        end else begin
            sysRst_q <= hfClearHit; // R06
        end
    end

    // Reset-pin ownership: every reset hands pin 0 back to the reset
    // function; software releases it once and cannot take it back
    // without a reset, which keeps a stray write from re-arming it.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            p1RstOwned_q <= 1'b1; // R11
        end else if (wrP1Rel && regWdata[gpp_pkg::REL_BIT]) begin
            p1RstOwned_q <= 1'b0; // R11
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (regRd) begin
            rdata_q <= rdMux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign regRdata = rdata_q;
    assign sysClkResetReq = sysRst_q;
    assign hfOscSelect = hfSel_q; // R05
    assign lfOscSelect = lfSel_q; // R05

    // Port 0 pads.
    assign p0PinOut = p0Out_q; // R02
    assign p0PinOe = p0Dir_q & ~oscOwned; // R01 R03
    assign p0PullupOn = port0_pullup_enable_q & ~p0Dir_q; // R07

    // Port 1 pads; the reset function keeps pin 0 an input.
    assign p1PinOut = p1Out_q; // R12
    assign p1PinOe = p1Dir_q & ~p1Owned; // R10 R11
    assign extResetInN = p1RstOwned_q ? p1Level[0] : 1'b1; // R11

    // Secondary inputs see the pin only while it is an input.
    assign p1SecondaryIn = p1Level[PINS-1:1] & ~p1Dir_q[PINS-1:1]; // R10

endmodule

// ---- rtl/gpp_pkg.sv ----
// Constants for the two four-bit general-purpose ports: register offsets,
// field positions, reset values and widths.
// Assumes a byte-wide register port with a 16-bit address.
package gpp_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PIN_W = 4;
    localparam int SYNC_W = 3;

    localparam logic [15:0] OFF_P0_OUT = 16'h0000;
    localparam logic [15:0] OFF_P1_OUT = 16'h0001;
    localparam logic [15:0] OFF_P0_PIN = 16'h000D;
    localparam logic [15:0] OFF_P0_DIR = 16'h0F1A;
    localparam logic [15:0] OFF_P1_DIR = 16'h0F1B;
    localparam logic [15:0] OFF_P0_PU = 16'h0F27;
    localparam logic [15:0] OFF_P0_FUNC = 16'h0F34;
    localparam logic [15:0] OFF_P1_RST_REL = 16'h0F80;
    localparam logic [15:0] OFF_P1_PIN = 16'h0F81;

    localparam logic [7:0] RST_P0_OUT = 8'h00;
    localparam logic [7:0] RST_P1_OUT = 8'h00;
    localparam logic [7:0] RST_P0_DIR = 8'h00;
    localparam logic [7:0] RST_P1_DIR = 8'h00;
    localparam logic [7:0] RST_P0_PU = 8'h00;
    localparam logic [7:0] RST_P0_FUNC = 8'h01;

    localparam int FUNC_HF_BIT = 0;
    localparam int FUNC_LF_BIT = 2;
    localparam int REL_BIT = 0;
    localparam logic [3:0] FUNC_IMPL_MASK = 4'h5;

endpackage

// ---- rtl/gpp_pin_sync.sv ----
// Three-stage input synchroniser with agreement filter for pin levels.
// Assumes asynchronous pin inputs and one clock with a synchronous reset.
`timescale 1ns/1ps
module gpp_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pinAsync,
    output logic [WIDTH-1:0] pinLevel
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_d;

    // A bit only moves once the last two stages agree, so a value caught
    // mid-settle in the second stage never reaches software.
    assign agree = ~(stage2_q ^ stage3_q);
    assign level_d = (agree & stage3_q) | (~agree & level_q);
    assign pinLevel = level_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            level_q <= '0;
        end else begin
            stage1_q <= pinAsync;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end

endmodule

// ---- verif/gpp_pad_model.sv ----
// Pad side of port 0: resolves each pin from the block, an outside driver and
// the pull-up. Assumes the testbench owns the outside driver's enable and level.
`timescale 1ns/1ps
module gpp_pad_model (
    input wire logic ref_clk,
    input wire logic [3:0] padOut,
    input wire logic [3:0] padOe,
    input wire logic [3:0] padPullup,
    input wire logic [3:0] extOe,
    input wire logic [3:0] extLevel,
    output logic [3:0] padLevel
);
    logic [3:0] floatQ = 4'h5;
    // A floating pin toggles every cycle, which the agreement filter never passes, so a missing pull-up reads as the pin's last settled level.
    always @(posedge ref_clk) floatQ <= ~floatQ;
    assign padLevel = (padOe & padOut) | (~padOe & extOe & extLevel)
        | (~padOe & ~extOe & (padPullup | floatQ));
endmodule

// ---- verif/gpp_ports_properties.sv ----
// Checker of register effects and pad gating for the port block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module gpp_ports_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic hfOscEnable,
    input wire logic sysClkResetReq,
    input wire logic hfOscSelect,
    input wire logic lfOscSelect,
    input wire logic [3:0] p0PinOut,
    input wire logic [3:0] p0PinOe,
    input wire logic [3:0] p0PullupOn
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire wrP0 = regWr && regAddr == 16'h0000;
    wire wrFn = regWr && regAddr == 16'h0F34;
    wire rstCause = wrFn && !regWdata[0] && hfOscEnable;
    sequence sWrRdP0;
        wrP0 ##2 regRd && regAddr == 16'h0000;
    endsequence
    AST_P0_LATCH: assert property (wrP0 |=> p0PinOut == $past(regWdata[3:0]))
        else $error("port 0 latch missed a write");
    AST_P0_HOLD: assert property (!wrP0 |=> $stable(p0PinOut))
        else $error("port 0 latch changed without a write");
    AST_FUNC_SEL: assert property (wrFn |=> hfOscSelect == $past(regWdata[0])
        && lfOscSelect == $past(regWdata[2])) else $error("function select wrong");
    AST_CLK_RST: assert property (rstCause |=> sysClkResetReq)
        else $error("clock reset request missing");
    AST_CLK_RST_CAUSE: assert property (sysClkResetReq |-> $past(rstCause))
        else $error("clock reset request without cause");
    AST_OSC_OE: assert property (!(|(p0PinOe & {{2{lfOscSelect}}, {2{hfOscSelect}}})))
        else $error("oscillator pin driven");
    AST_PULLUP: assert property (!(|(p0PullupOn & p0PinOe)))
        else $error("pull-up on an output pin");
    AST_RD_LATCH: assert property (sWrRdP0 |=> regRdata == {4'h0, $past(regWdata[3:0], 3)})
        else $error("latch read-back wrong");
    AST_RD_UPPER: assert property (regRd |=> regRdata[7:4] == 4'h0)
        else $error("upper read bits not zero");
endmodule

// ---- verif/tb_gpp_ports.sv ----
// Self-checking bench for the port block: register tasks and one task per scenario.
// Assumes the pad model on port 0 and the bound checker.
`timescale 1ns/1ps
module tb_gpp_ports;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic hfOscEnable = 1'b0;
    logic [3:0] extOe = 4'h0;
    logic [3:0] extLevel = 4'h0;
    logic [3:0] p1Ext = 4'hF;
    logic [7:0] regRdata;
    logic sysClkResetReq, hfOscSelect, lfOscSelect, extResetInN;
    logic [3:1] p1SecondaryIn;
    logic [3:0] p0PinIn, p0PinOut, p0PinOe, p0PullupOn, p1PinIn, p1PinOut, p1PinOe;
    int n_fail = 0;
    int n_checks = 0;
    always #2 ref_clk = ~ref_clk;
    assign p1PinIn = (p1PinOe & p1PinOut) | (~p1PinOe & p1Ext);
    gpp_ports uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .hfOscEnable(hfOscEnable),
        .sysClkResetReq(sysClkResetReq), .hfOscSelect(hfOscSelect), .lfOscSelect(lfOscSelect),
        .extResetInN(extResetInN), .p1SecondaryIn(p1SecondaryIn), .p0PinIn(p0PinIn),
        .p0PinOut(p0PinOut), .p0PinOe(p0PinOe), .p0PullupOn(p0PullupOn), .p1PinIn(p1PinIn),
        .p1PinOut(p1PinOut), .p1PinOe(p1PinOe));
    gpp_pad_model pads (.ref_clk(ref_clk), .padOut(p0PinOut), .padOe(p0PinOe),
        .padPullup(p0PullupOn), .extOe(extOe), .extLevel(extLevel), .padLevel(p0PinIn));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 check(regRdata, exp);
    endtask
    task automatic t_reset();
        #1 check({3'h0, hfOscSelect, p0PinOe}, 8'h10);
        rd(16'h0000, 8'h00);
        rd(16'h0001, 8'h00);
        rd(16'h0F1A, 8'h00);
        rd(16'h0F27, 8'h00);
        rd(16'h0F34, 8'h01);
    endtask
    task automatic t_regs();
        wr(16'h0000, 8'hFF);
        wr(16'h0F1A, 8'hFC);
        wr(16'h0F34, 8'hFF);
        wr(16'h0001, 8'hA5);
        rd(16'h0000, 8'h0F);
        rd(16'h0F1A, 8'h0C);
        rd(16'h0F34, 8'h05);
        rd(16'h0001, 8'h05);
        rd(16'h0100, 8'h00);
        check({p0PinOut, p0PinOe}, 8'hF0);
        wr(16'h0F34, 8'h01);
        #1 check({p0PinOut, p0PinOe}, 8'hFC);
        check({p1PinOut, 4'h0}, 8'h50);
    endtask
    task automatic t_pins();
        @(posedge ref_clk);
        extOe <= 4'hF;
        extLevel <= 4'hA;
        wr(16'h0F1A, 8'h00);
        wr(16'h0F34, 8'h00);
        repeat (6) @(posedge ref_clk);
        rd(16'h000D, 8'h0A);
        wr(16'h0F34, 8'h05);
        rd(16'h000D, 8'h00);
        wr(16'h0F34, 8'h00);
        wr(16'h0F1A, 8'h08);
        rd(16'h000D, 8'h02);
        @(posedge ref_clk);
        extOe <= 4'h0;
        wr(16'h0F27, 8'hFF);
        wr(16'h0F1A, 8'h04);
        #1 check({4'h0, p0PullupOn}, 8'h0B);
        repeat (6) @(posedge ref_clk);
        rd(16'h000D, 8'h0B);
    endtask
    task automatic t_clkrst();
        @(posedge ref_clk);
        hfOscEnable <= 1'b1;
        wr(16'h0F34, 8'h00);
        #1 check({7'h00, sysClkResetReq}, 8'h01);
        @(posedge ref_clk);
        #1 check({7'h00, sysClkResetReq}, 8'h00);
        wr(16'h0F34, 8'h01);
        #1 check({7'h00, sysClkResetReq}, 8'h00);
    endtask
    task automatic t_port1();
        #1 check({5'h00, p1SecondaryIn}, 8'h07);
        rd(16'h0F81, 8'h0E);
        @(posedge ref_clk);
        p1Ext <= 4'hE;
        wr(16'h0F1B, 8'h0F);
        repeat (6) @(posedge ref_clk);
        #1 check({3'h0, extResetInN, p1PinOe}, 8'h0E);
        check({5'h00, p1SecondaryIn}, 8'h00);
        rd(16'h0F1B, 8'h0F);
        rd(16'h0F80, 8'h00);
        wr(16'h0F80, 8'h01);
        #1 check({3'h0, extResetInN, p1PinOe}, 8'h1F);
        rd(16'h0F80, 8'h01);
    endtask
    // A second reset in mid-run must hand port 1 pin 0 back to the reset function.
    task automatic t_rerst();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1 check({3'h0, extResetInN, p1PinOe}, 8'h00);
        rd(16'h0F80, 8'h00);
        rd(16'h0001, 8'h00);
        wr(16'h0F1B, 8'h0F);
        #1 check({4'h0, p1PinOe}, 8'h0E);
        wr(16'h0000, 8'h06);
        rd(16'h0000, 8'h06);
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_pins();
        t_clkrst();
        t_port1();
        t_rerst();
        conclude();
    end
    // The scenarios need well under a thousand cycles, so 5000 cycles means a hang.
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
endmodule
bind gpp_ports gpp_ports_properties chk (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .hfOscEnable(hfOscEnable), .sysClkResetReq(sysClkResetReq), .hfOscSelect(hfOscSelect),
    .lfOscSelect(lfOscSelect), .p0PinOut(p0PinOut), .p0PinOe(p0PinOe), .p0PullupOn(p0PullupOn));
